// [hw/host_bus_strap_port.sv]
// Purpose: host bus control pins, straps and serial EEPROM clocking
// Assumes: all pins sampled synchronous to clk; APB slave with one wait state
// Notes: local_device_select_n is a combinational decode by intent
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps

module host_bus_strap_port #(
  parameter bit IS_32BIT = 1'b0,
  parameter int CMD_BITS = 16,
  parameter int DATA_BITS = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:1] hostAddr,
  input wire logic [15:0] hostData,
  input wire logic address_qualifier_n,
  input wire logic address_latch_strobe_n,
  input wire logic sync_write_read,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic bus_style_select,
  input wire logic eeprom_enable_strap,
  input wire logic eeprom_serial_in,
  input wire logic chip_power_down_n,
  output logic local_device_select_n,
  output logic eeprom_serial_clock,
  output logic eeprom_serial_out,
  output logic eepromSelect,
  output logic [15:1] latchedAddr,
  output logic latchedQualN,
  output logic cycleWrite,
  output logic writeAccept,
  output logic [15:0] writeData,
  output logic readRequest,
  output logic [1:0] busWidth,
  output logic asyncMode,
  output logic eepromPresent,
  output logic powerDown
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rstPipe_reg;
  logic rstN;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_reg <= 2'h0;
    end else begin
      rstPipe_reg <= {rstPipe_reg[0], 1'b1};
    end
  end
  assign rstN = rstPipe_reg[1];

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstN);

  // ----------------------------------------------------------------
  // straps
  // ----------------------------------------------------------------
  logic strapsTaken_reg;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      strapsTaken_reg <= 1'b0;
      eepromPresent <= 1'b0;
      asyncMode <= 1'b0;
      busWidth <= host_bus_strap_pkg::WIDTH_8;
    end else if (!strapsTaken_reg) begin
      // taken once; later strap motion is ignored until reset
      strapsTaken_reg <= 1'b1;
      eepromPresent <= eeprom_enable_strap;
      asyncMode <= bus_style_select;
      if (IS_32BIT) begin
        busWidth <= host_bus_strap_pkg::WIDTH_32;
      end else if (!eeprom_enable_strap && eeprom_serial_in) begin
        busWidth <= host_bus_strap_pkg::WIDTH_16;
      end else begin
        busWidth <= host_bus_strap_pkg::WIDTH_8;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      powerDown <= 1'b0;
    end else begin
      powerDown <= !chip_power_down_n;
    end
  end

  // ----------------------------------------------------------------
  // host pins
  // ----------------------------------------------------------------
  logic [7:0] baseHigh_reg;
  logic adsPrev_reg, wrPrev_reg, rdPrev_reg;
  logic adsRise, wrRise, rdFall;
  assign adsRise = adsPrev_reg && !address_latch_strobe_n ? 1'b0
                 : (!adsPrev_reg && address_latch_strobe_n);
  assign wrRise = !wrPrev_reg && write_strobe_n;
  assign rdFall = rdPrev_reg && !read_strobe_n;

  // combinational so the host sees select within the same address phase
  assign local_device_select_n = !(!address_qualifier_n &&
    hostAddr[15:8] == baseHigh_reg);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      adsPrev_reg <= 1'b1;
      wrPrev_reg <= 1'b1;
      rdPrev_reg <= 1'b1;
    end else begin
      adsPrev_reg <= address_latch_strobe_n;
      wrPrev_reg <= write_strobe_n;
      rdPrev_reg <= read_strobe_n;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      latchedAddr <= 15'h0000;
      latchedQualN <= 1'b1;
      cycleWrite <= 1'b0;
    end else if (adsRise && !powerDown) begin
      latchedAddr <= hostAddr;
      latchedQualN <= address_qualifier_n;
      if (!asyncMode && !address_qualifier_n) begin
        cycleWrite <= sync_write_read;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      writeAccept <= 1'b0;
      readRequest <= 1'b0;
      writeData <= 16'h0000;
    end else begin
      // strobes only count when qualified and in async style
      writeAccept <= wrRise && asyncMode && !address_qualifier_n &&
        !powerDown;
      readRequest <= rdFall && asyncMode && !address_qualifier_n &&
        !powerDown;
      if (wrRise && asyncMode && !address_qualifier_n && !powerDown) begin
        writeData <= hostData;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial EEPROM engine
  // ----------------------------------------------------------------
  localparam int HCW = host_bus_strap_pkg::HALF_CNT_W;
  host_bus_strap_pkg::ee_state_t eeState_reg;
  logic [1:0] speed_reg;
  logic [CMD_BITS-1:0] cmd_reg, cmdShift_reg;
  logic [DATA_BITS-1:0] eeData_reg;
  logic [HCW-1:0] phaseCnt_reg, halfLimit;
  logic [5:0] bitCnt_reg;
  logic startPulse, halfDone;

  assign halfLimit = (speed_reg == host_bus_strap_pkg::SPEED_SLOW) ?
    HCW'(host_bus_strap_pkg::EE_SLOW_HALF_CYC - 1) :
    HCW'(host_bus_strap_pkg::EE_FAST_HALF_CYC - 1);
  assign halfDone = phaseCnt_reg == halfLimit;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      eeState_reg <= host_bus_strap_pkg::EE_IDLE;
      phaseCnt_reg <= '0;
      bitCnt_reg <= 6'h00;
      cmdShift_reg <= '0;
      eeData_reg <= '0;
      eeprom_serial_clock <= 1'b0;
      eeprom_serial_out <= 1'b0;
      eepromSelect <= 1'b0;
    end else if (powerDown || !eepromPresent) begin
      eeState_reg <= host_bus_strap_pkg::EE_IDLE;
      phaseCnt_reg <= '0;
      eeprom_serial_clock <= 1'b0;
      eeprom_serial_out <= 1'b0;
      eepromSelect <= 1'b0;
    end else begin
      case (eeState_reg)
        host_bus_strap_pkg::EE_IDLE: begin
          if (startPulse) begin
            eeState_reg <= host_bus_strap_pkg::EE_SHIFT_OUT;
            cmdShift_reg <= cmd_reg << 1;
            eeprom_serial_out <= cmd_reg[CMD_BITS-1];
            eepromSelect <= 1'b1;
            bitCnt_reg <= 6'h00;
            phaseCnt_reg <= '0;
          end
        end
        host_bus_strap_pkg::EE_SHIFT_OUT,
        host_bus_strap_pkg::EE_SHIFT_IN: begin
          phaseCnt_reg <= halfDone ? '0 : phaseCnt_reg + 1'b1;
          if (halfDone) begin
            eeprom_serial_clock <= !eeprom_serial_clock;
            if (!eeprom_serial_clock &&
                eeState_reg == host_bus_strap_pkg::EE_SHIFT_IN) begin
              eeData_reg <= {eeData_reg[DATA_BITS-2:0],
                eeprom_serial_in};
            end
            if (eeprom_serial_clock) begin
              bitCnt_reg <= bitCnt_reg + 6'h01;
              if (eeState_reg == host_bus_strap_pkg::EE_SHIFT_OUT) begin
                eeprom_serial_out <= cmdShift_reg[CMD_BITS-1];
                cmdShift_reg <= cmdShift_reg << 1;
                if (bitCnt_reg == 6'(CMD_BITS - 1)) begin
                  eeState_reg <= host_bus_strap_pkg::EE_SHIFT_IN;
                  bitCnt_reg <= 6'h00;
                  eeprom_serial_out <= 1'b0;
                end
              end else if (bitCnt_reg == 6'(DATA_BITS - 1)) begin
                eeState_reg <= host_bus_strap_pkg::EE_IDLE;
                eepromSelect <= 1'b0;
              end
            end
          end
        end
        default: eeState_reg <= host_bus_strap_pkg::EE_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic apbDo, mapped;
  logic [31:0] rdMux;
  assign apbDo = psel && penable && !pready;
  assign startPulse = apbDo && pwrite && paddr == host_bus_strap_pkg::CTRL_OFS
    && pwdata[host_bus_strap_pkg::START_BIT];

  always_comb begin
    rdMux = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      host_bus_strap_pkg::CTRL_OFS: rdMux[1:0] = speed_reg;
      host_bus_strap_pkg::BASE_OFS: rdMux[7:0] = baseHigh_reg;
      host_bus_strap_pkg::EECMD_OFS: rdMux[CMD_BITS-1:0] = cmd_reg;
      host_bus_strap_pkg::EEDATA_OFS: rdMux[DATA_BITS-1:0] = eeData_reg;
      host_bus_strap_pkg::STATUS_OFS: begin
        rdMux[host_bus_strap_pkg::ST_BUSY] =
          eeState_reg != host_bus_strap_pkg::EE_IDLE;
        rdMux[host_bus_strap_pkg::ST_EEPRESENT] = eepromPresent;
        rdMux[host_bus_strap_pkg::ST_WIDTH_LSB +: 2] = busWidth;
        rdMux[host_bus_strap_pkg::ST_ASYNC] = asyncMode;
        rdMux[host_bus_strap_pkg::ST_CHIP_POWER_DOWN_N] = powerDown;
        rdMux[host_bus_strap_pkg::ST_CYCWRITE] = cycleWrite;
      end
      host_bus_strap_pkg::LATCH_OFS: begin
        rdMux[15:1] = latchedAddr;
        rdMux[host_bus_strap_pkg::LATCH_QUAL_BIT] = latchedQualN;
      end
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apbDo;
      pslverr <= apbDo && !mapped;
      prdata <= (apbDo && !pwrite) ? rdMux : 32'h0000_0000;
    end
  end

  // writes land on the completing edge only
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      speed_reg <= host_bus_strap_pkg::SPEED_RESET;
      baseHigh_reg <= host_bus_strap_pkg::BASE_RESET;
      cmd_reg <= '0;
    end else if (psel && penable && pready && pwrite) begin
      case (paddr)
        host_bus_strap_pkg::CTRL_OFS:
          speed_reg <= pwdata[host_bus_strap_pkg::SPEED_LSB +: 2];
        host_bus_strap_pkg::BASE_OFS: baseHigh_reg <= pwdata[7:0];
        host_bus_strap_pkg::EECMD_OFS: cmd_reg <= pwdata[CMD_BITS-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence syncQualLatch;
    !asyncMode && !address_qualifier_n && adsRise && !powerDown;
  endsequence

  dir_capture_a: assert property (syncQualLatch |=>
    cycleWrite == $past(sync_write_read)) else $error("direction lost");
  qual_gate_a: assert property (writeAccept || readRequest |->
    $past(!address_qualifier_n)) else $error("unqualified strobe");
  wr_strobe_a: assert property ($rose(write_strobe_n) && asyncMode &&
    !address_qualifier_n && !powerDown |=> writeAccept &&
    writeData == $past(hostData)) else $error("write not accepted");
  addr_latch_a: assert property (adsRise && !powerDown |=>
    latchedAddr == $past(hostAddr) &&
    latchedQualN == $past(address_qualifier_n))
    else $error("address not latched");
  width_strap_a: assert property ($rose(strapsTaken_reg) |->
    busWidth == (IS_32BIT ? host_bus_strap_pkg::WIDTH_32 :
    (!$past(eeprom_enable_strap) && $past(eeprom_serial_in)) ?
    host_bus_strap_pkg::WIDTH_16 : host_bus_strap_pkg::WIDTH_8))
    else $error("bad width");
  straps_hold_a: assert property (strapsTaken_reg |=>
    $stable(busWidth) && $stable(asyncMode) && $stable(eepromPresent))
    else $error("strap moved");
  pwr_down_a: assert property (!chip_power_down_n ##1 powerDown |=>
    eeState_reg == host_bus_strap_pkg::EE_IDLE && !eeprom_serial_clock)
    else $error("active in power-down");
  sclk_half_a: assert property ($changed(eeprom_serial_clock) &&
    eeState_reg != host_bus_strap_pkg::EE_IDLE |->
    $past(phaseCnt_reg) == $past(halfLimit)) else $error("clock period");
  ee_sample_a: assert property (halfDone && !eeprom_serial_clock &&
    eeState_reg == host_bus_strap_pkg::EE_SHIFT_IN && !powerDown &&
    eepromPresent |=> eeData_reg[0] == $past(eeprom_serial_in))
    else $error("data-in not sampled");
  ee_absent_a: assert property (!eepromPresent |=>
    eeState_reg == host_bus_strap_pkg::EE_IDLE) else $error("absent used");
  async_gate_a: assert property (!asyncMode |=> !writeAccept)
    else $error("async in sync style");
  local_sel_a: assert property (local_device_select_n ==
    !(!address_qualifier_n && hostAddr[15:8] == baseHigh_reg))
    else $error("select decode");

endmodule // host_bus_strap_port

// [hw/host_bus_strap_pkg.sv]
// Purpose: shared constants for the host bus strap port
// Assumes: 40 MHz system clock, APB register access
// Notes: all offsets are byte addresses of 32-bit words
package host_bus_strap_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int EE_SLOW_PERIOD_NS = 4000;
  localparam int EE_FAST_PERIOD_NS = 800;
  localparam int EE_SLOW_HALF_CYC = EE_SLOW_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int EE_FAST_HALF_CYC = EE_FAST_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int HALF_CNT_W = 8;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] BASE_OFS = 8'h04;
  localparam logic [7:0] EECMD_OFS = 8'h08;
  localparam logic [7:0] EEDATA_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] LATCH_OFS = 8'h14;

  // ctrl fields
  localparam int SPEED_LSB = 0;
  localparam int START_BIT = 2;
  localparam logic [1:0] SPEED_SLOW = 2'h3;
  localparam logic [1:0] SPEED_RESET = 2'h3;
  localparam logic [7:0] BASE_RESET = 8'h00;

  // status fields
  localparam int ST_BUSY = 0;
  localparam int ST_EEPRESENT = 1;
  localparam int ST_WIDTH_LSB = 2;
  localparam int ST_ASYNC = 4;
  localparam int ST_CHIP_POWER_DOWN_N = 5;
  localparam int ST_CYCWRITE = 6;
  localparam int LATCH_QUAL_BIT = 16;

  // bus width codes
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;

  typedef enum logic [1:0] {EE_IDLE, EE_SHIFT_OUT, EE_SHIFT_IN} ee_state_t;

endpackage

// [dv/eeprom_model.sv]
// Purpose: serial EEPROM stand-in on the configuration port
// Assumes: command bits shifted in on clock rise, MSB first
// Notes: the data line falls to its pull-down level when deselected
`timescale 1ns/100ps
module eeprom_model #(
  parameter int CMD_BITS = 16,
  parameter int DATA_BITS = 16
) (
  input wire logic serClk,
  input wire logic sel,
  input wire logic cmdIn,
  input wire logic [15:0] word,
  output logic dataOut = 1'b0,
  output logic [15:0] cmdSeen
);
  int rises = 0;

  always @(posedge serClk or negedge sel) begin
    if (!sel) begin
      rises <= 0;
    end else begin
      if (rises < CMD_BITS) begin
        cmdSeen <= {cmdSeen[14:0], cmdIn};
      end
      rises <= rises + 1;
    end
  end

  // answer changes on the fall so it is settled for the next rise
  always @(negedge serClk or negedge sel) begin
    if (!sel) begin
      dataOut <= 1'b0;
    end else if (rises >= CMD_BITS && rises < CMD_BITS + DATA_BITS) begin
      dataOut <= word[DATA_BITS - 1 - (rises - CMD_BITS)];
    end
  end
endmodule // eeprom_model

// [dv/host_bus_strap_port_tb.sv]
// Purpose: self-checking bench for the host bus strap port
// Assumes: 40 MHz clock; this bench is the APB master and host
// Notes: straps change around a reset and once inside t_async to check that they are held
`timescale 1ns/100ps
module host_bus_strap_port_tb;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [31:0] pwdata = 32'h0, prdata, rdat, wa, rr;
  logic rerr;
  logic [15:1] hostAddr = 15'h0, latchedAddr;
  logic [15:0] hostData = 16'h0, writeData, eeWord = 16'h0, cmdSeen;
  logic address_qualifier_n = 1'b1, address_latch_strobe_n = 1'b1;
  logic sync_write_read = 1'b0, write_strobe_n = 1'b1;
  logic read_strobe_n = 1'b1, bus_style_select = 1'b1;
  logic eeprom_enable_strap = 1'b0, chip_power_down_n = 1'b1;
  logic strapIn = 1'b1, eeData, local_device_select_n;
  logic eeprom_serial_clock, eeprom_serial_out, eepromSelect;
  logic latchedQualN, cycleWrite, writeAccept, readRequest;
  logic asyncMode, eepromPresent, powerDown;
  logic [1:0] busWidth;
  // strap level stands in for the EEPROM output when none is fitted
  wire logic eeprom_serial_in = eeprom_enable_strap ? eeData : strapIn;
  int errCount = 0, testsRun = 0, cycles = 0;

  host_bus_strap_port i_dut (
    .clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .hostAddr, .hostData, .address_qualifier_n,
    .address_latch_strobe_n, .sync_write_read, .write_strobe_n,
    .read_strobe_n, .bus_style_select, .eeprom_enable_strap,
    .eeprom_serial_in, .chip_power_down_n, .local_device_select_n,
    .eeprom_serial_clock, .eeprom_serial_out, .eepromSelect,
    .latchedAddr, .latchedQualN, .cycleWrite, .writeAccept, .writeData,
    .readRequest, .busWidth, .asyncMode, .eepromPresent, .powerDown);
  eeprom_model i_ee (.serClk(eeprom_serial_clock), .sel(eepromSelect),
    .cmdIn(eeprom_serial_out), .word(eeWord), .dataOut(eeData),
    .cmdSeen(cmdSeen));

  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errCount++;
      print_verdict();
    end
  end
  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] seen, exp);
    testsRun++;
    if (seen !== exp) begin
      errCount++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic reset_dut(input logic style, en, din);
    @(posedge clk);
    bus_style_select <= style;
    eeprom_enable_strap <= en;
    strapIn <= din;
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  // a one-cycle low pulse on the write (w=1) or read (w=0) strobe
  task automatic strobe(input logic w);
    @(posedge clk);
    write_strobe_n <= !w;
    read_strobe_n <= w;
    @(posedge clk);
    write_strobe_n <= 1'b1;
    read_strobe_n <= 1'b1;
    wa = 32'h0;
    rr = 32'h0;
    repeat (6) begin
      @(negedge clk);
      wa += writeAccept;
      rr += readRequest;
    end
  endtask
  task automatic sel_case(input logic q, input logic [7:0] hi,
      input logic exp);
    @(posedge clk);
    address_qualifier_n <= q;
    hostAddr <= {hi, 7'h2B};
    @(negedge clk);
    chk("select", local_device_select_n, exp);
  endtask
  task automatic latch(input logic [15:1] a, input logic q, sw);
    @(posedge clk);
    hostAddr <= a;
    address_qualifier_n <= q;
    sync_write_read <= sw;
    address_latch_strobe_n <= 1'b0;
    @(posedge clk);
    address_latch_strobe_n <= 1'b1;
    repeat (3) @(negedge clk);
    chk("latched addr", latchedAddr, a);
    chk("latched qual", latchedQualN, q);
  endtask
  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  task automatic t_async();
    rd(host_bus_strap_pkg::STATUS_OFS);
    chk("status", rdat, 32'h10 | {30'h0, host_bus_strap_pkg::WIDTH_16} <<
      host_bus_strap_pkg::ST_WIDTH_LSB);
    chk("width", busWidth, host_bus_strap_pkg::WIDTH_16);
    chk("present", eepromPresent, 1'b0);
    @(posedge clk);
    strapIn <= 1'b0;
    bus_style_select <= 1'b0;
    repeat (4) @(negedge clk);
    chk("width held", busWidth, host_bus_strap_pkg::WIDTH_16);
    chk("mode held", asyncMode, 1'b1);
    rd(host_bus_strap_pkg::CTRL_OFS);
    chk("ctrl", rdat, host_bus_strap_pkg::SPEED_RESET);
    rd(8'h18);
    chk("unmapped", {rerr, rdat[30:0]}, 32'h80000000);
    apb(1'b1, host_bus_strap_pkg::CTRL_OFS, 32'h4);
    repeat (4) @(negedge clk);
    chk("absent", eepromSelect, 1'b0);
    apb(1'b1, host_bus_strap_pkg::BASE_OFS, 32'hA5);
    rd(host_bus_strap_pkg::BASE_OFS);
    chk("base", rdat, 32'hA5);
    sel_case(1'b0, 8'hA5, 1'b0);
    sel_case(1'b1, 8'hA5, 1'b1);
    sel_case(1'b0, 8'hA4, 1'b1);
    sel_case(1'b0, 8'h25, 1'b1);
    @(posedge clk);
    hostData <= 16'h5A3C;
    strobe(1'b1);
    chk("write pulse", wa, 32'h1);
    chk("write data", writeData, 16'h5A3C);
    strobe(1'b0);
    chk("read pulse", {wa[15:0], rr[15:0]}, 32'h1);
    @(posedge clk);
    address_qualifier_n <= 1'b1;
    hostData <= 16'hC3A5;
    strobe(1'b1);
    chk("unqualified", wa, 32'h0);
    chk("data kept", writeData, 16'h5A3C);
    @(posedge clk);
    address_qualifier_n <= 1'b0;
    chip_power_down_n <= 1'b0;
    strobe(1'b1);
    chk("power down", powerDown, 1'b1);
    chk("pd write", wa, 32'h0);
    rd(host_bus_strap_pkg::STATUS_OFS);
    chk("pd status", rdat[host_bus_strap_pkg::ST_CHIP_POWER_DOWN_N], 1'b1);
    @(posedge clk);
    chip_power_down_n <= 1'b1;
    repeat (3) @(negedge clk);
    chk("awake", powerDown, 1'b0);
    $display("async style tests done");
  endtask
  task automatic t_sync();
    chk("sync mode", {asyncMode, eepromPresent}, 32'h1);
    chk("width 8", busWidth, host_bus_strap_pkg::WIDTH_8);
    latch(15'h1234, 1'b0, 1'b1);
    chk("write cycle", cycleWrite, 1'b1);
    rd(host_bus_strap_pkg::LATCH_OFS);
    chk("latch reg", rdat, 32'h2468);
    latch(15'h4ACF, 1'b0, 1'b0);
    chk("read cycle", cycleWrite, 1'b0);
    latch(15'h0F0F, 1'b1, 1'b1);
    chk("unqualified dir", cycleWrite, 1'b0);
    @(posedge clk);
    address_qualifier_n <= 1'b0;
    strobe(1'b1);
    chk("sync refuses", wa, 32'h0);
    $display("sync style tests done");
  endtask
  task automatic t_eeprom(input logic [1:0] sp, input int half);
    int n;
    eeWord <= {sp, 14'h26E5};
    apb(1'b1, host_bus_strap_pkg::EECMD_OFS, 32'hC35A);
    apb(1'b1, host_bus_strap_pkg::CTRL_OFS, {29'h0, 1'b1, sp});
    n = 0;
    while (eeprom_serial_clock !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (eeprom_serial_clock === 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk("half period", n, half);
    n = 0;
    do begin
      rd(host_bus_strap_pkg::STATUS_OFS);
      n++;
    end while (rdat[host_bus_strap_pkg::ST_BUSY] !== 1'b0 && n < 2000);
    chk("command", cmdSeen, 16'hC35A);
    rd(host_bus_strap_pkg::EEDATA_OFS);
    chk("eeprom data", rdat, {sp, 14'h26E5});
    $display("eeprom transfer test done");
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    reset_dut(1'b1, 1'b0, 1'b1);
    t_async();
    reset_dut(1'b0, 1'b1, 1'b0);
    t_sync();
    t_eeprom(2'h0, host_bus_strap_pkg::EE_FAST_HALF_CYC);
    t_eeprom(host_bus_strap_pkg::SPEED_SLOW,
      host_bus_strap_pkg::EE_SLOW_HALF_CYC);
    print_verdict();
  end
endmodule // host_bus_strap_port_tb
